// [design/reset_irq_core.sv]
// Reset sequencing and interrupt request expansion
//
// Behaviour
// - Reset overrides all; maskables start disabled
// - Reset comes from pin or watchdog
// - External lines need own enable and line mask
// - Peripheral events need own enable and mask
// - Software vector instruction branches, sets global mask
// - Non-maskable instruction branches to 24h, masks
// - No hardware non-maskable input exists
// - Trap branches to 22h, leaves mask
// - Emulator trap via vector or trap instruction
// - Peripheral sources grouped onto core lines 0 and 1 of the six
// - Each shared source keeps a distinct vector
// - Reset is first priority, vector 0000h
`timescale 1ns/1ps
`default_nettype none
`include "reset_irq_map.svh"
module reset_irq_core
   import reset_irq_pkg::*;
(
   input wire logic clk,
   input wire logic clk_en,
   input wire logic rst_b,
   input wire logic reset_pin_b,
   input wire logic watchdog_expire,
   input wire logic external_line_one,
   input wire logic external_line_two,
   input wire logic power_protect_line_a,
   input wire logic power_protect_line_b,
   input wire logic [3:0] ext_enable,
   input wire logic [7:0] periph_event,
   input wire logic [7:0] periph_enable,
   input wire logic [5:0] core_line_mask_register,
   input wire logic software_vector_instruction,
   input wire logic [15:0] sw_vector_operand,
   input wire logic nmi_instr,
   input wire logic trap_instr,
   input wire logic trap_emulate,
   input wire logic global_unmask,
   input wire logic core_ack,
   input wire logic [2:0] core_ack_line,
   output logic sys_reset_b,
   output logic [5:0] core_request_lines,
   output logic global_mask_bit,
   output logic branch_valid,
   output logic [15:0] branch_vector,
   output logic periph_vector_valid,
   output logic [15:0] periph_vector,
   output logic [11:0] pending
);
   localparam logic [191:0] PIV_TAB = `RIS_PIV_TABLE;
   localparam logic [35:0] GRP_TAB = `RIS_GRP_TABLE;

   logic [4:0] pin_s1, pin_s2, pin_prev;
   logic [4:0] next_pin_s1, next_pin_s2, next_pin_prev;
   seq_e state, next_state;
   logic next_sys_reset_b;
   logic [5:0] next_core_request_lines;
   logic next_global_mask_bit;
   logic next_branch_valid;
   vector_t next_branch_vector;
   logic next_periph_vector_valid;
   vector_t next_periph_vector;
   src_vec_t next_pending;

   src_vec_t member [`RIS_NUM_LINES];
   logic [5:0] line_req;
   src_idx_t line_sel [`RIS_NUM_LINES];
   logic [3:0] ext_rise;
   src_vec_t evt, clr;
   logic reset_req, acked;
   src_idx_t ack_sel;

   // Pin synchronisers, edge taken only after the second stage
   always_comb begin
      next_pin_s1 = {reset_pin_b, power_protect_line_b,
         power_protect_line_a, external_line_two, external_line_one};
      next_pin_s2 = pin_s1;
      next_pin_prev = pin_s2;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pin_s1 <= `RIS_PIN_RESET;
         pin_s2 <= `RIS_PIN_RESET;
         pin_prev <= `RIS_PIN_RESET;
      end else if (clk_en) begin
         pin_s1 <= next_pin_s1;
         pin_s2 <= next_pin_s2;
         pin_prev <= next_pin_prev;
      end
   end

   // One expander per core line
   for (genvar g = 0; g < `RIS_NUM_LINES; g++) begin : gen_line
      group_if gi();
      for (genvar i = 0; i < `RIS_NUM_SRC; i++) begin : gen_mem
         assign member[g][i] = (GRP_TAB[i*3 +: 3] == 3'(g));
      end
      assign gi.pend = pending;
      assign gi.member = member[g];
      assign line_req[g] = gi.req;
      assign line_sel[g] = gi.sel;
      group_expander u_exp (
         .grp(gi.exp)
      );
   end

   // Event gathering and acknowledge decode
   always_comb begin
      reset_req = ~pin_s2[4] | watchdog_expire;
      ext_rise = pin_s2[3:0] & ~pin_prev[3:0];
      evt = 12'h000;
      evt[`RIS_SRC_X1] = ext_rise[0] & ext_enable[0];
      evt[`RIS_SRC_X2] = ext_rise[1] & ext_enable[1];
      evt[`RIS_SRC_PP_A] = ext_rise[2] & ext_enable[2];
      evt[`RIS_SRC_PP_B] = ext_rise[3] & ext_enable[3];
      evt[`RIS_SRC_ADC] = periph_event[0] & periph_enable[0];
      evt[`RIS_SRC_SPI] = periph_event[1] & periph_enable[1];
      evt[`RIS_SRC_SCI_RX] = periph_event[2] & periph_enable[2];
      evt[`RIS_SRC_SCI_TX] = periph_event[3] & periph_enable[3];
      evt[`RIS_SRC_CAN_MB] = periph_event[4] & periph_enable[4];
      evt[`RIS_SRC_CAN_ERR] = periph_event[5] & periph_enable[5];
      evt[`RIS_SRC_CMP1] = periph_event[6] & periph_enable[6];
      evt[`RIS_SRC_CMP4] = periph_event[7] & periph_enable[7];
      acked = 1'b0;
      ack_sel = 4'h0;
      if (core_ack && core_ack_line < 3'(`RIS_NUM_LINES)) begin
         acked = line_req[core_ack_line];
         ack_sel = line_sel[core_ack_line];
      end
      clr = acked ? src_vec_t'(12'h001 << ack_sel) : 12'h000;
   end

   // Reset sequencer, pending store, mask and branch logic
   always_comb begin
      next_state = state;
      next_sys_reset_b = sys_reset_b;
      next_pending = pending;
      next_global_mask_bit = global_mask_bit;
      next_branch_valid = 1'b0;
      next_branch_vector = branch_vector;
      next_periph_vector_valid = 1'b0;
      next_periph_vector = periph_vector;
      next_core_request_lines = 6'h00;
      if (reset_req) begin
         // Overrides everything in progress
         next_state = ST_HOLD;
         next_sys_reset_b = 1'b0;
         next_pending = 12'h000;
         next_global_mask_bit = `RIS_GMASK_RESET;
      end else begin
         unique case (state)
            ST_HOLD: begin
               next_state = ST_RUN;
               next_sys_reset_b = 1'b1;
               next_branch_valid = 1'b1;
               next_branch_vector = `RIS_VEC_RESET;
            end
            ST_RUN: begin
               // New event wins over a same-cycle clear
               next_pending = (pending & ~clr) | evt;
               if (acked) begin
                  next_periph_vector_valid = 1'b1;
                  next_periph_vector = PIV_TAB[ack_sel*16 +: 16];
               end
               // Only software reaches the non-maskable vector
               if (nmi_instr) begin
                  next_branch_valid = 1'b1;
                  next_branch_vector = `RIS_VEC_NMI;
               end else if (software_vector_instruction) begin
                  next_branch_valid = 1'b1;
                  next_branch_vector = sw_vector_operand;
               end else if (trap_instr) begin
                  next_branch_valid = 1'b1;
                  next_branch_vector = trap_emulate ? `RIS_VEC_EMU :
                     `RIS_VEC_TRAP;
               end
               if (nmi_instr || software_vector_instruction || acked) begin
                  next_global_mask_bit = 1'b1;
               end else if (global_unmask) begin
                  next_global_mask_bit = 1'b0;
               end
               next_core_request_lines = line_req & core_line_mask_register
                  & {6{~global_mask_bit}};
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= ST_HOLD;
         sys_reset_b <= 1'b0;
         pending <= 12'h000;
         global_mask_bit <= `RIS_GMASK_RESET;
         branch_valid <= 1'b0;
         branch_vector <= `RIS_VEC_RESET;
         periph_vector_valid <= 1'b0;
         periph_vector <= 16'h0000;
         core_request_lines <= 6'h00;
      end else if (clk_en) begin
         state <= next_state;
         sys_reset_b <= next_sys_reset_b;
         pending <= next_pending;
         global_mask_bit <= next_global_mask_bit;
         branch_valid <= next_branch_valid;
         branch_vector <= next_branch_vector;
         periph_vector_valid <= next_periph_vector_valid;
         periph_vector <= next_periph_vector;
         core_request_lines <= next_core_request_lines;
      end
   end
endmodule
`default_nettype wire

// [common/reset_irq_map.svh]
// Constant map of the reset and interrupt request structure
`ifndef RESET_IRQ_MAP_SVH
`define RESET_IRQ_MAP_SVH

`define RIS_NUM_SRC 12
`define RIS_NUM_LINES 6
`define RIS_NUM_EXT 4
`define RIS_NUM_PERIPH 8
`define RIS_NUM_PINS 5

// Fixed core vectors
`define RIS_VEC_RESET 16'h0000
`define RIS_VEC_TRAP 16'h0022
`define RIS_VEC_NMI 16'h0024
`define RIS_VEC_EMU 16'h0026

// Reset values
`define RIS_GMASK_RESET 1'h1
`define RIS_PIN_RESET 5'h10

// Source index, highest priority first
`define RIS_SRC_PP_A 0
`define RIS_SRC_PP_B 1
`define RIS_SRC_ADC 2
`define RIS_SRC_X1 3
`define RIS_SRC_X2 4
`define RIS_SRC_SPI 5
`define RIS_SRC_SCI_RX 6
`define RIS_SRC_SCI_TX 7
`define RIS_SRC_CAN_MB 8
`define RIS_SRC_CAN_ERR 9
`define RIS_SRC_CMP1 10
`define RIS_SRC_CMP4 11

// Peripheral vector per source, source 0 in the low bits
`define RIS_PIV_TABLE {16'h0024, 16'h0021, 16'h0041, 16'h0040, \
   16'h0007, 16'h0006, 16'h0005, 16'h0011, 16'h0001, 16'h0004, \
   16'h0019, 16'h0020}

// Core line per source, source 0 in the low bits
`define RIS_GRP_TABLE {3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, \
   3'h0, 3'h0, 3'h0, 3'h0, 3'h0}

`endif

// [common/reset_irq_pkg.sv]
// Types of the reset and interrupt request structure
package reset_irq_pkg;
   typedef enum logic [1:0] {
      ST_HOLD = 2'b01,
      ST_RUN = 2'b10
   } seq_e;
   typedef logic [15:0] vector_t;
   typedef logic [3:0] src_idx_t;
   typedef logic [11:0] src_vec_t;
endpackage

// [common/group_if.sv]
// Carrier between the pending store and one line expander
`timescale 1ns/1ps
`default_nettype none
interface group_if;
   import reset_irq_pkg::*;
   src_vec_t pend;
   src_vec_t member;
   logic req;
   src_idx_t sel;
   modport exp (input pend, input member, output req, output sel);
   modport top (output pend, output member, input req, input sel);
endinterface
`default_nettype wire

// [design/group_expander.sv]
// Picks the highest-priority pending source of one core line
`timescale 1ns/1ps
`default_nettype none
`include "reset_irq_map.svh"
module group_expander
   import reset_irq_pkg::*;
(
   group_if.exp grp
);
   src_vec_t hits;

   always_comb begin
      hits = grp.pend & grp.member;
      grp.req = |hits;
      grp.sel = 4'h0;
      for (int i = `RIS_NUM_SRC - 1; i >= 0; i--) begin
         if (hits[i]) begin
            grp.sel = src_idx_t'(i);
         end
      end
   end
endmodule
`default_nettype wire

// [dv/reset_irq_properties.sv]
// Concurrent checks on the reset and interrupt structure ports
`timescale 1ns/1ps
`default_nettype none
module reset_irq_properties (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic watchdog_expire,
   input wire logic [5:0] core_line_mask_register,
   input wire logic software_vector_instruction,
   input wire logic nmi_instr,
   input wire logic trap_instr,
   input wire logic trap_emulate,
   input wire logic global_unmask,
   input wire logic core_ack,
   input wire logic [2:0] core_ack_line,
   input wire logic sys_reset_b,
   input wire logic [5:0] core_request_lines,
   input wire logic global_mask_bit,
   input wire logic branch_valid,
   input wire logic [15:0] branch_vector,
   input wire logic periph_vector_valid,
   input wire logic [15:0] periph_vector,
   input wire logic [11:0] pending
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence ack_s;
      core_ack && core_ack_line == 3'h0 && pending[2:0] == 3'h4;
   endsequence
   sequence vec_s;
      periph_vector_valid && periph_vector == 16'h0004 && global_mask_bit;
   endsequence
   a_release_vec: assert property (
      $rose(sys_reset_b) |-> branch_valid && branch_vector == 16'h0000)
      else $error("release without reset vector");
   a_wdog_reset: assert property (
      watchdog_expire |=> !sys_reset_b)
      else $error("watchdog did not reset");
   a_hold_quiet: assert property (
      !sys_reset_b |-> core_request_lines == 6'h00 && global_mask_bit)
      else $error("request or unmasked during reset");
   a_nmi_branch: assert property (
      sys_reset_b && !watchdog_expire && nmi_instr |=> branch_valid
      && branch_vector == 16'h0024 && global_mask_bit)
      else $error("bad non-maskable branch");
   a_trap_keeps: assert property (
      sys_reset_b && !watchdog_expire && trap_instr && !(trap_emulate
      || nmi_instr || software_vector_instruction || core_ack
      || global_unmask) |=> branch_vector == 16'h0022
      && $stable(global_mask_bit))
      else $error("bad trap branch");
   a_line_gated: assert property (
      |core_request_lines |-> !$past(global_mask_bit) && (core_request_lines
      & ~$past(core_line_mask_register)) == 6'h00)
      else $error("request through a mask");
   a_ack_top: assert property (
      ack_s |=> vec_s)
      else $error("bad acknowledge vector");
   a_idle_ack: assert property (
      core_ack && core_ack_line > 3'h5 |=> !periph_vector_valid)
      else $error("answer on absent line");
endmodule
bind reset_irq_core reset_irq_properties chk_u (.*);
`default_nettype wire

// [dv/core_model.sv]
// Core stand-in that acknowledges shared request lines
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clk,
   input wire logic take,
   input wire logic global_mask_bit,
   input wire logic [5:0] lines,
   output logic ack,
   output logic [2:0] line
);
   always_ff @(posedge clk) begin
      ack <= 1'b0;
      line <= 3'h0;
      for (int i = 5; i >= 0; i--)
         if (take && !global_mask_bit && !ack && lines[i]) begin
            ack <= 1'b1;
            line <= 3'(i);
         end
   end
endmodule
`default_nettype wire

// [dv/reset_irq_core_bench.sv]
// Bench of the reset and interrupt structure
`timescale 1ns/1ps
`default_nettype none
module reset_irq_core_bench;
   logic clk, rst_b, pin_b, wdog, unmask, take, tb_ack, m_ack, sys_b;
   logic gmask, bv, pv_ok;
   logic [3:0] ins, ext_en;
   logic [2:0] tb_line, m_line;
   logic [11:0] stim, pend;
   logic [7:0] per_en;
   logic [5:0] lmask, lines;
   logic [15:0] op, bvec, pvec;
   int miscompares, checks_done;
   logic [31:0] rows [12] = '{32'h0012_0004, 32'h0025_0005, 32'h0046_0006,
      32'h0087_0007, 32'h0108_0040, 32'h0209_0041, 32'h040a_0021,
      32'h080b_0024, 32'h1003_0001, 32'h2004_0011, 32'h4000_0020,
      32'h8001_0019};
   logic [23:0] instrs [4] = '{24'h81_0024, 24'h41_0026, 24'h20_0022,
      24'h30_0026};
   reset_irq_core dut_u (.clk(clk), .clk_en(1'b1), .rst_b(rst_b),
      .reset_pin_b(pin_b), .watchdog_expire(wdog),
      .external_line_one(stim[8]), .external_line_two(stim[9]),
      .power_protect_line_a(stim[10]), .power_protect_line_b(stim[11]),
      .ext_enable(ext_en), .periph_event(stim[7:0]), .periph_enable(per_en),
      .core_line_mask_register(lmask), .software_vector_instruction(ins[2]),
      .sw_vector_operand(op), .nmi_instr(ins[3]), .trap_instr(ins[1]),
      .trap_emulate(ins[0]), .global_unmask(unmask),
      .core_ack(m_ack | tb_ack), .core_ack_line(tb_ack ? tb_line : m_line),
      .sys_reset_b(sys_b), .core_request_lines(lines),
      .global_mask_bit(gmask), .branch_valid(bv), .branch_vector(bvec),
      .periph_vector_valid(pv_ok), .periph_vector(pvec), .pending(pend));
   core_model core_u (.clk(clk), .take(take), .global_mask_bit(gmask),
      .lines(lines), .ack(m_ack), .line(m_line));
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic fire(input logic [11:0] s);
      stim = s;
      tick(1);
      stim = '0;
      tick(5);
   endtask
   task automatic serve(input logic [15:0] vec, input logic [5:0] ln);
      unmask = 1;
      tick(1);
      unmask = 0;
      tick(1);
      chk(lines, ln);
      take = 1;
      for (int i = 0; i < 9 && pv_ok !== 1'b1; i++)
         tick(1);
      chk(pv_ok, 1'b1);
      chk(pvec, vec);
      take = 0;
      tick(1);
   endtask
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   initial begin
      #40000;
      miscompares++;
      end_sim;
   end
   initial begin
      {rst_b, wdog, unmask, take, tb_ack, ins, stim, tb_line} = '0;
      {pin_b, op, ext_en, per_en, lmask} = {1'b1, 16'h0026, 18'h3_ffff};
      tick(6);
      rst_b = 1;
      tick(1);
      chk(bv, 1'b1);
      chk(sys_b, 1'b1);
      tick(1);
      chk(bvec, 16'h0000);
      chk(gmask, 1'b1);
      foreach (rows[r]) begin
         fire(rows[r][31:20]);
         chk(pend, 16'h0001 << rows[r][19:16]);
         serve(rows[r][15:0], rows[r][19:16] > 9 ? 6'h02 : 6'h01);
         chk(pend, 16'h0000);
      end
      fire(12'h003);
      chk(pend, 16'h0024);
      serve(16'h0004, 6'h01);
      serve(16'h0005, 6'h01);
      {per_en, ext_en} = 12'hfe_e;
      fire(12'h101);
      chk(pend, 16'h0000);
      {per_en, ext_en, lmask} = {12'hff_f, 6'h3e};
      fire(12'h001);
      unmask = 1;
      tick(1);
      unmask = 0;
      tick(1);
      chk(lines, 6'h00);
      lmask = 6'h3f;
      serve(16'h0004, 6'h01);
      fire(12'h001);
      {tb_ack, tb_line} = 4'hf;
      tick(1);
      tb_ack = 0;
      chk(pv_ok, 1'b0);
      chk(pend, 16'h0004);
      foreach (instrs[i]) begin
         unmask = 1;
         tick(1);
         unmask = 0;
         ins = instrs[i][23:20];
         tick(1);
         ins = '0;
         chk(bv, 1'b1);
         chk(bvec, instrs[i][15:0]);
         chk(gmask, instrs[i][16]);
      end
      fire(12'h001);
      wdog = 1;
      tick(1);
      wdog = 0;
      chk(sys_b, 1'b0);
      tick(2);
      chk(sys_b, 1'b1);
      chk(pend, 16'h0000);
      pin_b = 0;
      tick(4);
      chk(sys_b, 1'b0);
      pin_b = 1;
      tick(6);
      chk(sys_b, 1'b1);
      end_sim;
   end
endmodule
`default_nettype wire
